// *** verilog/amrc_pkg.sv ***
// Purpose: constants and carriers for the converter register block
// Assumes: byte-wide internal register bus, one clock
// Notes: offsets are the register addresses on the core's bus
package amrc_pkg;
   localparam logic [7:0] ADDR_MUX = 8'hd7;
   localparam logic [7:0] ADDR_IRQ = 8'hd8;
   localparam logic [7:0] ADDR_RESL = 8'hd9;
   localparam logic [7:0] ADDR_RESM = 8'hda;
   localparam logic [7:0] ADDR_RESH = 8'hdb;
   localparam logic [7:0] ADDR_AFC = 8'hdc;
   localparam logic [7:0] RST_MUX = 8'h01;
   localparam logic [7:0] RST_AFC = 8'h30;
   localparam logic [7:0] MUX_TEMP_ALL = 8'hff;
   // fixed bits of the interrupt control byte: bit 6 one, others zero
   localparam logic [7:0] IRQ_FIXED = 8'h40;
   localparam int IRQ_EN_BIT = 5;
   localparam int IRQ_AUX_BIT = 4;
   localparam int IRQ_WDG_BIT = 3;
   localparam int AFC_USED_MSB = 6;
   localparam int GAIN_W = 3;
   localparam int SEL_W = 4;
   localparam int AUX_SOURCES = 9;
   localparam logic [3:0] SEL_AIN5 = 4'h5;
   localparam logic [3:0] SEL_REFN_A = 4'h6;
   localparam logic [3:0] SEL_REFN_B = 4'h7;
   localparam logic [3:0] SEL_COM = 4'h8;
   localparam logic [3:0] SEL_TEMP = 4'hf;

   typedef enum logic [2:0] {
      SRC_AIN, SRC_REFN, SRC_COM, SRC_TEMP, SRC_RSVD
   } amrc_src_e;

   typedef struct packed {
      amrc_src_e kind;
      logic [2:0] ain;
   } amrc_route_s;

   typedef struct packed {
      logic burnout;
      logic intRef;
      logic refHigh;
      logic buffer;
      logic [GAIN_W-1:0] gainCode;
   } amrc_afe_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } amrc_bus_s;
endpackage

// *** verilog/amrc_result_fmt.sv ***
// Purpose: arrange a converter word into three result bytes
// Assumes: wide variant uses all 24 bits, narrow variant low 16
// Notes: purely combinational
`timescale 1ns/1ps
module amrc_result_fmt #(
   parameter int WIDE = 1
) (
   input wire logic [23:0] rawWord,
   input wire logic unipolar,
   output logic [23:0] fmtWord
);
   always_comb begin
      if (WIDE != 0) begin
         fmtWord = rawWord;
      end else if (!unipolar && rawWord[15]) begin
         fmtWord = {8'hff, rawWord[15:0]};
      end else begin
         fmtWord = {8'h00, rawWord[15:0]};
      end
   end
endmodule // amrc_result_fmt

// *** verilog/amrc_regs.sv ***
// Purpose: converter mux, interrupt flag, result and front-end registers
// Assumes: core register bus synchronous to clk_sys, one access a cycle
// Notes: rdData is registered, valid the cycle after rd
//
// Summary of operation
// - upper nibble selects positive input: ain0-5, ref-, common, temp
// - lower nibble selects negative input with the same code set
// - enable bit gates the merged nine-source auxiliary interrupt
// - writing one to the auxiliary flag raises it if enabled
// - writing one to watchdog flag raises watchdog interrupt
// - watchdog interrupt only when watchdog reset action is off
// - reading result low clears conversion-done source; flag separate
// - wide variant: low, mid, high bytes; narrow: mid is top
// - narrow variant high byte is sign copies or zeros
// - polarity zero bipolar, one unipolar, steers extension
`timescale 1ns/1ps
module amrc_regs #(
   parameter int WIDE = 1
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire amrc_pkg::amrc_bus_s bus,
   output logic [7:0] rdData,
   input wire logic convDone,
   input wire logic [23:0] convWord,
   input wire logic resultPolarity,
   input wire logic auxSourceIrq,
   input wire logic wdgTimeout,
   input wire logic wdgResetEnable,
   output logic convDoneIrq,
   output logic auxIrq,
   output logic wdgIrq,
   output amrc_pkg::amrc_route_s posRoute,
   output amrc_pkg::amrc_route_s negRoute,
   output logic tempSensorSel,
   output amrc_pkg::amrc_afe_s afe,
   output logic [7:0] gainFactor
);
   logic [7:0] mux_r, mux_nxt;
   logic [7:0] afc_r, afc_nxt;
   logic auxEn_r, auxEn_nxt;
   logic auxFlag_r, auxFlag_nxt;
   logic wdgFlag_r, wdgFlag_nxt;
   logic done_r, done_nxt;
   logic [23:0] res_r, res_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic [23:0] fmtWord;
   logic wrMux, wrIrq, wrAfc, rdLow;

   function automatic amrc_pkg::amrc_route_s decodeSel(
      input logic [3:0] code
   );
      amrc_pkg::amrc_route_s r;
      r.ain = code[2:0];
      if (code <= amrc_pkg::SEL_AIN5) begin
         r.kind = amrc_pkg::SRC_AIN;
      end else if (code == amrc_pkg::SEL_REFN_A ||
                   code == amrc_pkg::SEL_REFN_B) begin
         r.kind = amrc_pkg::SRC_REFN;
      end else if (code == amrc_pkg::SEL_COM) begin
         r.kind = amrc_pkg::SRC_COM;
      end else if (code == amrc_pkg::SEL_TEMP) begin
         r.kind = amrc_pkg::SRC_TEMP;
      end else begin
         r.kind = amrc_pkg::SRC_RSVD;
      end
      return r;
   endfunction

   function automatic amrc_pkg::amrc_afe_s amrc_afe_cast(
      input logic [7:0] v
   );
      return amrc_pkg::amrc_afe_s'(v[amrc_pkg::AFC_USED_MSB:0]);
   endfunction

   amrc_result_fmt #(.WIDE(WIDE)) u_fmt (
      .rawWord(convWord),
      .unipolar(resultPolarity),
      .fmtWord(fmtWord)
   );

   assign wrMux = bus.wr && bus.addr == amrc_pkg::ADDR_MUX;
   assign wrIrq = bus.wr && bus.addr == amrc_pkg::ADDR_IRQ;
   assign wrAfc = bus.wr && bus.addr == amrc_pkg::ADDR_AFC;
   assign rdLow = bus.rd && bus.addr == amrc_pkg::ADDR_RESL;

   always_comb begin
      mux_nxt = wrMux ? bus.wdata : mux_r;
      afc_nxt = afc_r;
      if (wrAfc) begin
         afc_nxt = {1'b0, bus.wdata[amrc_pkg::AFC_USED_MSB:0]};
      end
      auxEn_nxt = auxEn_r;
      auxFlag_nxt = auxFlag_r;
      wdgFlag_nxt = wdgFlag_r;
      if (wrIrq) begin
         auxEn_nxt = bus.wdata[amrc_pkg::IRQ_EN_BIT];
         // software may set or clear; written one raises the request
         auxFlag_nxt = bus.wdata[amrc_pkg::IRQ_AUX_BIT];
         wdgFlag_nxt = bus.wdata[amrc_pkg::IRQ_WDG_BIT];
      end
      // hardware set wins over a same-cycle clear
      if (auxSourceIrq) begin
         auxFlag_nxt = 1'b1;
      end
      if (wdgTimeout && !wdgResetEnable) begin
         wdgFlag_nxt = 1'b1;
      end
      done_nxt = done_r;
      if (rdLow) begin
         done_nxt = 1'b0;
      end
      if (convDone) begin
         done_nxt = 1'b1;
      end
      // whole word latched at once, no torn reads
      res_nxt = convDone ? fmtWord : res_r;
      unique case (bus.addr)
         amrc_pkg::ADDR_MUX: rd_nxt = mux_r;
         amrc_pkg::ADDR_IRQ: rd_nxt = amrc_pkg::IRQ_FIXED |
            ({7'h00, auxEn_r} << amrc_pkg::IRQ_EN_BIT) |
            ({7'h00, auxFlag_r} << amrc_pkg::IRQ_AUX_BIT) |
            ({7'h00, wdgFlag_r} << amrc_pkg::IRQ_WDG_BIT);
         amrc_pkg::ADDR_RESL: rd_nxt = res_r[7:0];
         amrc_pkg::ADDR_RESM: rd_nxt = res_r[15:8];
         amrc_pkg::ADDR_RESH: rd_nxt = res_r[23:16];
         amrc_pkg::ADDR_AFC: rd_nxt = afc_r;
         default: rd_nxt = 8'h00;
      endcase
      if (!bus.rd) begin
         rd_nxt = rd_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mux_r <= amrc_pkg::RST_MUX;
         afc_r <= amrc_pkg::RST_AFC;
         auxEn_r <= 1'b0;
         auxFlag_r <= 1'b0;
         wdgFlag_r <= 1'b0;
         done_r <= 1'b0;
         res_r <= 24'h000000;
         rd_r <= 8'h00;
      end else if (clkEn) begin
         mux_r <= mux_nxt;
         afc_r <= afc_nxt;
         auxEn_r <= auxEn_nxt;
         auxFlag_r <= auxFlag_nxt;
         wdgFlag_r <= wdgFlag_nxt;
         done_r <= done_nxt;
         res_r <= res_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign rdData = rd_r;
   assign convDoneIrq = done_r;
   assign auxIrq = auxEn_r && auxFlag_r;
   // flag left set requests only while wdgResetEnable is low, until software clears it
   assign wdgIrq = wdgFlag_r && !wdgResetEnable;
   assign posRoute = decodeSel(mux_r[7:4]);
   assign negRoute = decodeSel(mux_r[3:0]);
   // sensor valid only when the whole byte is ones
   assign tempSensorSel = mux_r == amrc_pkg::MUX_TEMP_ALL;
   assign afe = amrc_afe_cast(afc_r);
   assign gainFactor = 8'h01 << afc_r[amrc_pkg::GAIN_W-1:0];

   property p_aux_gate;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wrIrq && !bus.wdata[amrc_pkg::IRQ_EN_BIT] |=> !auxIrq;
   endproperty
   a_aux_gate: assert property (p_aux_gate)
      else $error("aux irq without enable");

   property p_aux_set;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wrIrq && bus.wdata[amrc_pkg::IRQ_AUX_BIT] &&
         bus.wdata[amrc_pkg::IRQ_EN_BIT] |=> auxIrq;
   endproperty
   a_aux_set: assert property (p_aux_set)
      else $error("aux write did not raise irq");

   property p_wdg_set;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wrIrq && bus.wdata[amrc_pkg::IRQ_WDG_BIT]
         |=> wdgFlag_r;
   endproperty
   a_wdg_set: assert property (p_wdg_set)
      else $error("watchdog flag write lost");

   property p_wdg_block;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wdgTimeout && wdgResetEnable && !wrIrq |=> $stable(wdgFlag_r);
   endproperty
   a_wdg_block: assert property (p_wdg_block)
      else $error("watchdog irq while reset action on");

   property p_done_clr;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && rdLow && !convDone |=> !convDoneIrq;
   endproperty
   a_done_clr: assert property (p_done_clr)
      else $error("low read did not clear done");

   property p_res_load;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && convDone |=> res_r == $past(fmtWord);
   endproperty
   a_res_load: assert property (p_res_load)
      else $error("result bytes not loaded together");

   property p_res_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      !convDone |=> $stable(res_r);
   endproperty
   a_res_hold: assert property (p_res_hold)
      else $error("result changed without conversion");

   property p_temp;
      @(posedge clk_sys) disable iff (sys_rst)
      tempSensorSel |-> posRoute.kind == amrc_pkg::SRC_TEMP &&
         negRoute.kind == amrc_pkg::SRC_TEMP;
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature route mismatch");

   property p_ext;
      @(posedge clk_sys) disable iff (sys_rst)
      WIDE == 0 && !resultPolarity && convWord[15] && convDone && clkEn
         |=> res_r[23:16] == 8'hff;
   endproperty
   a_ext: assert property (p_ext)
      else $error("sign extension missing");

   property p_rsvd;
      @(posedge clk_sys) disable iff (sys_rst)
      mux_r[7:4] > amrc_pkg::SEL_COM && mux_r[7:4] < amrc_pkg::SEL_TEMP
         |-> posRoute.kind == amrc_pkg::SRC_RSVD;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved code routed");

   property p_aux_hw;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && auxSourceIrq |=> auxFlag_r;
   endproperty
   a_aux_hw: assert property (p_aux_hw)
      else $error("aux source request lost");

   property p_wdg_hw;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wdgTimeout && !wdgResetEnable |=> wdgFlag_r;
   endproperty
   a_wdg_hw: assert property (p_wdg_hw)
      else $error("watchdog timeout lost");

   property p_pos_ain;
      @(posedge clk_sys) disable iff (sys_rst)
      mux_r[7:4] <= amrc_pkg::SEL_AIN5 |->
         posRoute.kind == amrc_pkg::SRC_AIN && posRoute.ain == mux_r[6:4];
   endproperty
   a_pos_ain: assert property (p_pos_ain)
      else $error("positive analog input misrouted");

   property p_neg_ref;
      @(posedge clk_sys) disable iff (sys_rst)
      mux_r[3:0] == amrc_pkg::SEL_REFN_A ||
         mux_r[3:0] == amrc_pkg::SEL_REFN_B
         |-> negRoute.kind == amrc_pkg::SRC_REFN;
   endproperty
   a_neg_ref: assert property (p_neg_ref)
      else $error("negative reference misrouted");

   property p_zero_ext;
      @(posedge clk_sys) disable iff (sys_rst)
      WIDE == 0 && resultPolarity && convDone && clkEn
         |=> res_r[23:16] == 8'h00;
   endproperty
   a_zero_ext: assert property (p_zero_ext)
      else $error("unipolar high byte not zero");

   property p_gain_load;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && wrAfc
         |=> afe.gainCode == $past(bus.wdata[amrc_pkg::GAIN_W-1:0]);
   endproperty
   a_gain_load: assert property (p_gain_load)
      else $error("gain code not loaded");

   c_temp: cover property (@(posedge clk_sys) tempSensorSel);
   c_aux: cover property (@(posedge clk_sys) auxIrq);
   c_done: cover property (@(posedge clk_sys) convDoneIrq ##1 !convDoneIrq);
   c_wdg: cover property (@(posedge clk_sys) wdgIrq);
   c_rsvd: cover property (@(posedge clk_sys) posRoute.kind == amrc_pkg::SRC_RSVD);
endmodule // amrc_regs

// *** testbench/amrc_core_model.sv ***
// Purpose: processor core side of the register bus
// Assumes: strobes last one edge, read data the cycle after
// Notes: released lines show inverted values, not stale ones
`timescale 1ns/1ps
module amrc_core_model (
   input wire logic clk_sys,
   output amrc_pkg::amrc_bus_s bus,
   input wire logic [7:0] rdData
);
   initial bus = '0;
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      bus <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_sys);
      // idle lines toggle so a stale address cannot pass
      bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1 q = rdData;
   endtask
endmodule // amrc_core_model

// *** testbench/adc_mux_result_ctrl_regs_tb_top.sv ***
// Purpose: self-checking bench for the converter register block
// Assumes: wide and narrow instances share the bus
// Notes: narrowSel picks whose read data the core sees
`timescale 1ns/1ps
module adc_mux_result_ctrl_regs_tb_top;
   logic clk_sys = 0, sys_rst = 1, convDone = 0, resultPolarity = 0;
   logic auxSourceIrq = 0, wdgTimeout = 0, wdgResetEnable = 1, clkEn = 1;
   logic narrowSel = 0, tempSensorSel, convDoneIrq, auxIrq, wdgIrq, result_polarity;
   logic [23:0] convWord = '0, w, got, e;
   logic [7:0] q, rdW, rdN, gainFactor, d;
   logic [7:0] ra [7] = '{8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hd0};
   logic [7:0] rv [7] = '{8'h01, 8'h40, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00};
   amrc_pkg::amrc_bus_s bus;
   amrc_pkg::amrc_route_s posRoute, negRoute;
   amrc_pkg::amrc_afe_s afe;
   int err_total = 0, comparisons = 0;
   always #2 clk_sys = ~clk_sys;
   amrc_core_model core (.clk_sys, .bus,
      .rdData(narrowSel ? rdN : rdW));
   amrc_regs #(.WIDE(1)) DUT (.clk_sys, .sys_rst, .clkEn, .bus,
      .rdData(rdW), .convDone, .convWord, .resultPolarity, .auxSourceIrq,
      .wdgTimeout, .wdgResetEnable, .convDoneIrq, .auxIrq, .wdgIrq,
      .posRoute, .negRoute, .tempSensorSel, .afe, .gainFactor);
   amrc_regs #(.WIDE(0)) dutNarrow (.clk_sys, .sys_rst, .clkEn,
      .bus, .rdData(rdN), .convDone, .convWord, .resultPolarity,
      .auxSourceIrq, .wdgTimeout, .wdgResetEnable, .convDoneIrq(),
      .auxIrq(), .wdgIrq(), .posRoute(), .negRoute(), .tempSensorSel(),
      .afe(), .gainFactor());
   function automatic logic [23:0] fmt(logic [23:0] x, logic p, logic wd);
      return wd ? x : {p ? 8'h00 : {8{x[15]}}, x[15:0]};
   endfunction
   function automatic amrc_pkg::amrc_src_e kindOf(logic [3:0] c);
      if (c < 4'h6) return amrc_pkg::SRC_AIN;
      if (c < 4'h8) return amrc_pkg::SRC_REFN;
      if (c == 4'h8) return amrc_pkg::SRC_COM;
      if (c == 4'hf) return amrc_pkg::SRC_TEMP;
      return amrc_pkg::SRC_RSVD;
   endfunction
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // sel 0 conversion done, 1 aux source, 2 watchdog timeout
   task automatic pulse(input int sel);
      @(posedge clk_sys);
      if (sel == 0) convDone <= 1'b1;
      else if (sel == 1) auxSourceIrq <= 1'b1;
      else wdgTimeout <= 1'b1;
      @(posedge clk_sys);
      {convDone, auxSourceIrq, wdgTimeout} <= 3'b000;
      #1;
   endtask
   task automatic checkResets();
      foreach (ra[i]) begin
         core.xfer(0, ra[i], 8'h00, q);
         check(24'(q), 24'(rv[i]));
      end
   endtask
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
   initial begin
      void'($urandom(54316));
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      checkResets();
      for (int c = 0; c < 16; c++) begin
         // equal nibbles, so ff is the only temperature case
         core.xfer(1, 8'hd7, {2{4'(c)}}, q);
         check(24'(posRoute.kind), 24'(kindOf(4'(c))));
         check(24'(negRoute.kind), 24'(kindOf(4'(c))));
         check(24'(tempSensorSel), 24'(c == 15));
         if (c < 6) check(24'(posRoute.ain), 24'(c));
         if (c < 6) check(24'(negRoute.ain), 24'(c));
      end
      core.xfer(1, 8'hd7, 8'hf1, q);
      check(24'(tempSensorSel), 24'h0);
      d = 8'($urandom);
      core.xfer(1, 8'hd7, d, q);
      core.xfer(0, 8'hd7, 8'h00, q);
      check(24'(q), 24'(d));
      // enable low: the write must not land
      @(posedge clk_sys);
      clkEn <= 1'b0;
      core.xfer(1, 8'hd7, ~d, q);
      check(24'(posRoute.kind), 24'(kindOf(d[7:4])));
      @(posedge clk_sys);
      clkEn <= 1'b1;
      core.xfer(0, 8'hd7, 8'h00, q);
      check(24'(q), 24'(d));
      for (int g = 0; g < 8; g++) begin
         d = {1'b1, 4'($urandom), 3'(g)};
         core.xfer(1, 8'hdc, d, q);
         core.xfer(0, 8'hdc, 8'h00, q);
         check(24'(q), {17'h0, d[6:0]});
         check(24'(gainFactor), 24'(1) << g);
         check(24'(afe), {17'h0, d[6:0]});
      end
      core.xfer(1, 8'hd8, 8'h10, q);
      check(24'(auxIrq), 24'h0);
      core.xfer(0, 8'hd8, 8'h00, q);
      check(24'(q), 24'h50);
      core.xfer(1, 8'hd8, 8'h30, q);
      check(24'(auxIrq), 24'h1);
      core.xfer(1, 8'hd8, 8'h20, q);
      check(24'(auxIrq), 24'h0);
      pulse(1);
      check(24'(auxIrq), 24'h1);
      pulse(2);
      core.xfer(0, 8'hd8, 8'h00, q);
      check(24'(q), 24'h70);
      core.xfer(1, 8'hd8, 8'h08, q);
      check(24'(wdgIrq), 24'h0);
      @(posedge clk_sys);
      wdgResetEnable <= 1'b0;
      #1 check(24'(wdgIrq), 24'h1);
      core.xfer(1, 8'hd8, 8'h00, q);
      check(24'(wdgIrq), 24'h0);
      pulse(2);
      check(24'(wdgIrq), 24'h1);
      core.xfer(1, 8'hd8, 8'h00, q);
      for (int i = 0; i < 8; i++) begin
         // first pair forces a negative narrow word in both polarities
         w = (i < 2) ? 24'h7f8000 : 24'($urandom);
         result_polarity = (i < 2) ? 1'(i) : 1'($urandom);
         @(posedge clk_sys);
         convWord <= w;
         resultPolarity <= result_polarity;
         pulse(0);
         check(24'(convDoneIrq), 24'h1);
         for (int n = 0; n < 2; n++) begin
            narrowSel = 1'(n);
            for (int b = 0; b < 3; b++) begin
               core.xfer(0, 8'hd9 + 8'(b), 8'h00, q);
               got[8*b +: 8] = q;
            end
            check(24'(convDoneIrq), 24'h0);
            e = fmt(w, result_polarity, !narrowSel);
            check(got, e);
            check(24'(got[15:8]), 24'(e[15:8]));
         end
         narrowSel = 1'b0;
      end
      // mid-run reset with a pending done flag and loaded results
      pulse(0);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      check(24'(convDoneIrq), 24'h0);
      checkResets();
      complete_run();
   end
endmodule // adc_mux_result_ctrl_regs_tb_top
